// >>> inc/twp_map.svh
`ifndef TWP_MAP_SVH
`define TWP_MAP_SVH

// Register offsets
`define TWP_TMR_OFFSET 8'h05
// Timer control field positions
`define TWP_CTL_RATIO_LSB 0
`define TWP_CTL_EDGE_BIT 4
`define TWP_CTL_SRC_BIT 5
// Watchdog control field positions
`define TWP_WDC_RATIO_LSB 2
`define TWP_WDC_PSEN_BIT 5
`define TWP_WDC_EN_BIT 7
// Reset values
`define TWP_TMR_RST 8'h00
`define TWP_CTL_RST 8'h00
`define TWP_WDC_RST 8'h00
// Writable bit masks, other bits read as zero
`define TWP_CTL_MASK 8'h3F
`define TWP_WDC_MASK 8'hBC
// Timing
`define TWP_CLK_PERIOD_NS 10
`define TWP_WDOG_TIMEOUT_MS 18
`define TWP_WDOG_BASE_CYCLES ((`TWP_WDOG_TIMEOUT_MS * 1000000) / `TWP_CLK_PERIOD_NS)

`endif

// >>> inc/twp_pkg.sv
`default_nettype none

package twp_pkg;

  typedef struct packed {
    logic [1:0] unused_hi;
    logic src_ext;
    logic edge_fall;
    logic unused_3;
    logic [2:0] ratio;
  } twp_ctl_t;

  typedef struct packed {
    logic enable;
    logic unused_6;
    logic pre_en;
    logic [2:0] ratio;
    logic [1:0] unused_lo;
  } twp_wdc_t;

endpackage

`default_nettype wire

// >>> rtl/twp_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "twp_map.svh"

module twp_top
  import twp_pkg::*;
#(
  parameter int unsigned WDOG_BASE_CYCLES = `TWP_WDOG_BASE_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Core register access
  input wire logic TMR_WE,
  input wire logic CTL_WE,
  input wire logic WDC_WE,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] TMR_RDATA,
  output logic [7:0] CTL_RDATA,
  output logic [7:0] WDC_RDATA,
  // Core instructions and power state
  input wire logic WDOG_CLEAR_INSTR,
  input wire logic SLEEP_INSTR,
  input wire logic SLEEPING,
  // External timer input
  input wire logic TMR_PIN,
  // Events
  output logic TMR_OVF,
  output logic WDOG_RST
);

  // Prescaler terminal count for ratio 1:(2 << sel)
  function automatic logic ratio_hit(input logic [7:0] cnt, input logic [2:0] sel);
    logic [8:0] div;
    div = 9'h002 << sel;
    ratio_hit = (cnt == 8'(div - 9'h001));
  endfunction

  logic [7:0] tmr_ff;
  logic [7:0] tmr_pre_ff;
  logic [7:0] ctl_ff;
  logic [7:0] wdc_ff;
  logic pin_ff;
  logic ovf_ff;
  logic [20:0] wd_base_ff;
  logic [7:0] wd_pre_ff;
  logic wd_rst_ff;
  twp_ctl_t ctl;
  twp_wdc_t wdc;
  logic ext_edge;
  logic src_tick;
  logic tmr_inc;
  logic base_hit;
  logic wd_clr;
  logic wd_timeout;

  assign ctl = twp_ctl_t'(ctl_ff);
  assign wdc = twp_wdc_t'(wdc_ff);

  // Control registers
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ctl_ff <= `TWP_CTL_RST;
    end else if (CTL_WE) begin
      ctl_ff <= REG_WDATA & `TWP_CTL_MASK;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wdc_ff <= `TWP_WDC_RST;
    end else if (WDC_WE) begin
      wdc_ff <= REG_WDATA & `TWP_WDC_MASK;
    end
  end

  // Pin history for edge detect; lets one sample per level suffice
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pin_ff <= 1'b0;
    end else begin
      pin_ff <= TMR_PIN;
    end
  end

  assign ext_edge = ctl.edge_fall ? (pin_ff & ~TMR_PIN) : (~pin_ff & TMR_PIN);
  // source select; internal source halts in sleep
  assign src_tick = ctl.src_ext ? ext_edge : ~SLEEPING;
  assign tmr_inc = src_tick & ratio_hit(tmr_pre_ff, ctl.ratio);

  // timer prescaler; cleared by counter write
  always_ff @(posedge CLK) begin
    if (SYS_RST || TMR_WE) begin
      tmr_pre_ff <= 8'h00;
    end else if (tmr_inc) begin
      tmr_pre_ff <= 8'h00;
    end else if (src_tick) begin
      tmr_pre_ff <= tmr_pre_ff + 8'h01;
    end
  end

  // 8-bit counter; write wins over count; wraps
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      tmr_ff <= `TWP_TMR_RST;
    end else if (TMR_WE) begin
      tmr_ff <= REG_WDATA;
    end else if (tmr_inc) begin
      tmr_ff <= tmr_ff + 8'h01;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ovf_ff <= 1'b0;
    end else begin
      ovf_ff <= ~TMR_WE & tmr_inc & (tmr_ff == 8'hFF);
    end
  end

  // clear instructions; own time-out resets too
  assign wd_clr = WDOG_CLEAR_INSTR | SLEEP_INSTR | wd_rst_ff | ~wdc.enable;
  assign base_hit = (wd_base_ff == 21'(WDOG_BASE_CYCLES - 1));
  // prescaler bypass gives 1:1
  // Clear in the last base cycle must beat the time-out
  assign wd_timeout = wdc.enable & base_hit & ~WDOG_CLEAR_INSTR & ~SLEEP_INSTR &
    (~wdc.pre_en | ratio_hit(wd_pre_ff, wdc.ratio));

  always_ff @(posedge CLK) begin
    if (SYS_RST || wd_clr || base_hit) begin
      wd_base_ff <= 21'h0_0000;
    end else begin
      wd_base_ff <= wd_base_ff + 21'h0_0001;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST || wd_clr || wd_timeout) begin
      wd_pre_ff <= 8'h00;
    end else if (base_hit && wdc.pre_en) begin
      wd_pre_ff <= wd_pre_ff + 8'h01;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wd_rst_ff <= 1'b0;
    end else begin
      wd_rst_ff <= wd_timeout;
    end
  end

  assign TMR_RDATA = tmr_ff;
  assign CTL_RDATA = ctl_ff;
  assign WDC_RDATA = wdc_ff;
  assign TMR_OVF = ovf_ff;
  assign WDOG_RST = wd_rst_ff;

  sequence s_write_tmr;
    TMR_WE;
  endsequence

  chk_write_loads: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_write_tmr |=> (tmr_ff == $past(REG_WDATA)))
    else $error("Counter write not loaded");
  chk_write_clears_pre: assert property (@(posedge CLK) disable iff (SYS_RST)
    s_write_tmr |=> (tmr_pre_ff == 8'h00))
    else $error("Timer prescaler not cleared by write");
  chk_sleep_halts: assert property (@(posedge CLK) disable iff (SYS_RST)
    (SLEEPING && !ctl.src_ext && !TMR_WE && !CTL_WE) |=> $stable(tmr_ff))
    else $error("Internal count ran in sleep");
  chk_ext_edge_count: assert property (@(posedge CLK) disable iff (SYS_RST)
    (ctl.src_ext && !ext_edge && !TMR_WE && !CTL_WE) |=> $stable(tmr_ff) && $stable(tmr_pre_ff))
    else $error("External count without edge");
  chk_wrap_ovf: assert property (@(posedge CLK) disable iff (SYS_RST)
    (tmr_inc && !TMR_WE && tmr_ff == 8'hFF) |=> (TMR_OVF && tmr_ff == 8'h00))
    else $error("Wrap without overflow pulse");
  chk_ovf_pulse: assert property (@(posedge CLK) disable iff (SYS_RST)
    TMR_OVF |=> !TMR_OVF)
    else $error("Overflow longer than one cycle");
  chk_wd_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
    (WDOG_CLEAR_INSTR || SLEEP_INSTR) |=> (wd_base_ff == 21'h0_0000 && wd_pre_ff == 8'h00))
    else $error("Watchdog not cleared by instruction");
  chk_wd_disabled: assert property (@(posedge CLK) disable iff (SYS_RST)
    (!wdc.enable) [*2] |-> !WDOG_RST)
    else $error("Watchdog reset while disabled");
  chk_wd_bypass: assert property (@(posedge CLK) disable iff (SYS_RST)
    (wdc.enable && !wdc.pre_en && base_hit && !WDOG_CLEAR_INSTR && !SLEEP_INSTR) |=> WDOG_RST)
    else $error("Bypassed watchdog missed time-out");
  chk_wd_rst_clears: assert property (@(posedge CLK) disable iff (SYS_RST)
    WDOG_RST |=> (wd_base_ff == 21'h0_0000 && wd_pre_ff == 8'h00))
    else $error("Watchdog state survived its reset");
  chk_clear_beats_timeout: assert property (@(posedge CLK) disable iff (SYS_RST)
    (WDOG_CLEAR_INSTR || SLEEP_INSTR) |=> !WDOG_RST)
    else $error("Watchdog fired despite clear instruction");
  chk_sys_rst_wd: assert property (@(posedge CLK)
    SYS_RST |=> (wd_base_ff == 21'h0_0000 && wd_pre_ff == 8'h00))
    else $error("Watchdog state survived device reset");

endmodule

`default_nettype wire

// >>> test/timer_watchdog_prescaler_bench.sv
`timescale 1ns/1ps
`default_nettype none

module timer_watchdog_prescaler_bench;
  localparam int BASE = 8;
  logic clk, sys_rst, tmr_pin, tmr_we, ctl_we, wdc_we, clr_i, slp_i, slp_lv, tmr_ovf, wdog_rst;
  logic [7:0] wdata, tmr_rd, ctl_rd, wdc_rd;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  int n;

  twp_core_model core (.clk(clk), .tmr_we(tmr_we), .ctl_we(ctl_we), .wdc_we(wdc_we), .wdata(wdata),
    .clr_instr(clr_i), .slp_instr(slp_i), .sleeping(slp_lv));
  twp_top #(.WDOG_BASE_CYCLES(BASE)) DUT (.CLK(clk), .SYS_RST(sys_rst), .TMR_WE(tmr_we), .CTL_WE(ctl_we),
    .WDC_WE(wdc_we), .REG_WDATA(wdata), .TMR_RDATA(tmr_rd), .CTL_RDATA(ctl_rd), .WDC_RDATA(wdc_rd),
    .WDOG_CLEAR_INSTR(clr_i), .SLEEP_INSTR(slp_i), .SLEEPING(slp_lv), .TMR_PIN(tmr_pin),
    .TMR_OVF(tmr_ovf), .WDOG_RST(wdog_rst));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Cycles from a request until the chosen event, capped at lim
  task automatic wait_ev(input logic wd, input int lim, output int k);
    k = 1;
    while (k < lim && (wd ? wdog_rst : tmr_ovf) !== 1'b1) begin
      @(negedge clk);
      k++;
    end
  endtask

  task automatic t_regs();
    chk("tmr reset", tmr_rd, 16'h0000);
    chk("ctl reset", ctl_rd, 16'h0000);
    chk("wdc reset", wdc_rd, 16'h0000);
    core.wr(2'd1, 8'hFF);
    chk("ctl mask", ctl_rd, 16'h003F);
    core.wr(2'd2, 8'hFF);
    chk("wdc mask", wdc_rd, 16'h00BC);
    core.wr(2'd2, 8'h00);
    core.wr(2'd0, 8'hA5);
    chk("tmr write", tmr_rd, 16'h00A5);
  endtask

  task automatic t_wrap();
    core.wr(2'd1, 8'h00);
    core.wr(2'd0, 8'hFE);
    wait_ev(1'b0, 50, n);
    chk("ovf cycle", 16'(n), 16'h0005);
    chk("wrap value", tmr_rd, 16'h0000);
  endtask

  task automatic t_ratio_sleep();
    core.wr(2'd1, 8'h02);
    core.wr(2'd0, 8'h00);
    repeat (79) @(negedge clk);
    // Write left prescaler at 0, so 79 ticks give nine counts
    chk("ratio count", tmr_rd, 16'h0009);
    core.sleeping = 1'b1;
    repeat (30) @(negedge clk);
    chk("sleep hold", tmr_rd, 16'h0009);
    core.sleeping = 1'b0;
  endtask

  task automatic t_ext(input logic [7:0] ctl, input logic [15:0] exp);
    tmr_pin = 1'b0;
    repeat (4) @(negedge clk);
    core.wr(2'd1, ctl);
    core.wr(2'd0, 8'h00);
    repeat (7) begin
      repeat (3) @(negedge clk);
      tmr_pin = ~tmr_pin;
    end
    repeat (4) @(negedge clk);
    chk("ext edges", tmr_rd, exp);
  endtask

  task automatic t_wdog_ratio();
    for (int c = 0; c < 8; c++) begin
      core.wr(2'd2, {3'b101, 3'(c), 2'b00});
      core.sleeping = c[0];
      core.instr(1'b1, 1'b0);
      wait_ev(1'b1, 3000, n);
      // Counting starts in the cycle after the clear edge
      chk("wdog ratio", 16'(n), 16'(BASE * (2 << c) + 1));
    end
    core.sleeping = 1'b0;
  endtask

  task automatic t_wdog_clear();
    core.wr(2'd2, 8'h80);
    for (int i = 0; i < 6; i++) begin
      wait_ev(1'b1, 6, n);
      chk("wdog held", 16'(n), 16'h0006);
      core.instr(i[0], ~i[0]);
    end
    wait_ev(1'b1, 50, n);
    chk("wdog bypass", 16'(n), 16'(BASE + 1));
  endtask

  task automatic t_wdog_off();
    core.wr(2'd2, 8'h00);
    wait_ev(1'b1, 100, n);
    chk("wdog off", 16'(n), 16'h0064);
  endtask

  // Ceiling well above the roughly 4500 cycles of the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    sys_rst = 1'b1;
    tmr_pin = 1'b0;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    t_regs();
    t_wrap();
    t_ratio_sleep();
    t_ext(8'h30, 16'h0001);
    t_ext(8'h20, 16'h0002);
    t_wdog_ratio();
    t_wdog_clear();
    t_wdog_off();
    final_report();
  end
endmodule

`default_nettype wire

// >>> test/twp_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module twp_core_model (
  // Clock
  input wire logic clk,
  // Register writes
  output logic tmr_we,
  output logic ctl_we,
  output logic wdc_we,
  output logic [7:0] wdata,
  // Instructions and power state
  output logic clr_instr,
  output logic slp_instr,
  output logic sleeping
);
  initial begin
    {tmr_we, ctl_we, wdc_we, wdata, clr_instr, slp_instr, sleeping} = '0;
  end

  // One-cycle strobe, set and dropped on falling edges
  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    @(negedge clk);
    tmr_we = (sel == 2'd0);
    ctl_we = (sel == 2'd1);
    wdc_we = (sel == 2'd2);
    wdata = d;
    @(negedge clk);
    {tmr_we, ctl_we, wdc_we} = '0;
  endtask

  task automatic instr(input logic clr, input logic slp);
    @(negedge clk);
    clr_instr = clr;
    slp_instr = slp;
    @(negedge clk);
    clr_instr = 1'b0;
    slp_instr = 1'b0;
  endtask
endmodule

`default_nettype wire
